// *** rtl/sei2c_params.svh ***
/*
 * Constants for the serial engine I2C master pin block: start-up modes,
 * port widths, pin positions, clock divider and idle UART levels.
 * Assumes inclusion by bare name before the package.
 */
`ifndef SEI2C_PARAMS_SVH
`define SEI2C_PARAMS_SVH

`define SEI2C_PORT_W 8
`define SEI2C_SCL_BIT 0
`define SEI2C_SDO_BIT 1
`define SEI2C_SDI_BIT 2
// Quarter bit period in ns; 100 kHz bus gives 2500 ns per quarter
`define SEI2C_QUARTER_NS 2500
`define SEI2C_CLK_NS 5
`define SEI2C_QUARTER_CYC ((`SEI2C_QUARTER_NS) / (`SEI2C_CLK_NS))
// Idle UART levels on the low port: TXD high, RTS high, DTR high
`define SEI2C_UART_IDLE 8'h0D
`define SEI2C_UART_IDLE_OE 8'h0D
// High port lines kept by FIFO functions while in FIFO mode
`define SEI2C_FIFO_HI_MASK 8'h0F
`define SEI2C_ENGINE_OE_LOW 8'h03

`endif

// *** rtl/sei2c_pkg.sv ***
/*
 * Types for the serial engine I2C master pin block.
 * Assumes the params header is on the include path.
 */
package sei2c_pkg;
    typedef enum logic [1:0] {
        SEI2C_BOOT_UART = 2'h0,
        SEI2C_BOOT_FIFO = 2'h1
    } sei2c_boot_t;

    typedef enum logic [2:0] {
        SEI2C_CMD_START = 3'h0,
        SEI2C_CMD_STOP = 3'h1,
        SEI2C_CMD_WRITE = 3'h2,
        SEI2C_CMD_READ = 3'h3,
        SEI2C_CMD_IDLE = 3'h4
    } sei2c_cmd_t;

    typedef enum {
        SEI2C_ST_BOOT,
        SEI2C_ST_READY,
        SEI2C_ST_START,
        SEI2C_ST_STOP,
        SEI2C_ST_BITS,
        SEI2C_ST_ACK,
        SEI2C_ST_DONE
    } sei2c_state_t;
endpackage

// *** rtl/sei2c_master.sv ***
/*
 * Serial engine acting as I2C master on low-port pins, plus GPIO on
 * the remaining low-port and high-port lines.
 * Assumes a host-side command source on the same clock, and a board that
 * ties the data-out and data-in pins together with a pull-up.
 */
`timescale 1ns/100ps
`include "sei2c_params.svh"

// What this block does
// - Master only, never answers as slave
// - Sole master, no arbitration logic
// - Low bit 0 drives SCL in engine mode
// - Three-phase: data stable across both edges
// - Per-line drive-only-zero on both ports
// - FIFO start: all low lines tristated
// - UART start: low lines at UART idle
// - Engine mode entered from either start mode
// - FIFO-owned high lines not free GPIO
// - Spare low and high lines are GPIO in engine mode
module sei2c_master import sei2c_pkg::*; (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic BOOT_FIFO_I,
    input wire logic ENGINE_EN_I,
    input wire logic THREE_PHASE_I,
    input wire logic CMD_VALID_I,
    input wire logic [2:0] CMD_I,
    input wire logic [7:0] CMD_DATA_I,
    input wire logic CMD_NACK_I,
    input wire logic [7:0] LO_DIR_I,
    input wire logic [7:0] LO_VAL_I,
    input wire logic [7:0] LO_OD_I,
    input wire logic [7:0] HI_DIR_I,
    input wire logic [7:0] HI_VAL_I,
    input wire logic [7:0] HI_OD_I,
    input wire logic [7:0] HI_FIFO_VAL_I,
    input wire logic [7:0] LO_PIN_I,
    input wire logic [7:0] HI_PIN_I,
    output logic [7:0] LO_PIN_O,
    output logic [7:0] LO_PIN_OE_O,
    output logic [7:0] HI_PIN_O,
    output logic [7:0] HI_PIN_OE_O,
    output logic ENGINE_MODE_O,
    output logic CMD_READY_O,
    output logic DONE_O,
    output logic ACK_O,
    output logic [7:0] RD_DATA_O,
    output logic [7:0] LO_IN_O,
    output logic [7:0] HI_IN_O
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [7:0] lo_s1_reg, lo_s2_reg, hi_s1_reg, hi_s2_reg;
    logic boot_s1_reg, boot_s2_reg;
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            lo_s1_reg <= 8'hFF;
            lo_s2_reg <= 8'hFF;
            hi_s1_reg <= 8'hFF;
            hi_s2_reg <= 8'hFF;
            boot_s1_reg <= 1'h0;
            boot_s2_reg <= 1'h0;
        end else begin
            lo_s1_reg <= LO_PIN_I;
            lo_s2_reg <= lo_s1_reg;
            hi_s1_reg <= HI_PIN_I;
            hi_s2_reg <= hi_s1_reg;
            boot_s1_reg <= BOOT_FIFO_I;
            boot_s2_reg <= boot_s1_reg;
        end
    end

    // ****************************************************************
    // Quarter-period enable and bit sequencer
    // ****************************************************************
    localparam int QCYC = (`SEI2C_QUARTER_CYC < 1) ? 1 : `SEI2C_QUARTER_CYC;
    logic [15:0] div_reg;
    wire tick = (div_reg == 16'(QCYC - 1));

    sei2c_state_t state_reg;
    sei2c_boot_t boot_reg;
    logic [1:0] phase_reg;
    logic [2:0] bit_reg;
    logic [2:0] cmd_reg;
    logic [7:0] sh_reg;
    logic nack_reg, scl_reg, sdo_reg;
    wire sda_in = lo_s2_reg[`SEI2C_SDI_BIT];
    // Three-phase holds data two quarters past the falling edge, two-phase one quarter
    wire [1:0] last_phase = THREE_PHASE_I ? 2'h3 : 2'h2;
    wire phase_end = tick && (phase_reg == last_phase);
    wire is_read = (cmd_reg == SEI2C_CMD_READ);

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            div_reg <= 16'h0000;
            state_reg <= SEI2C_ST_BOOT;
            boot_reg <= SEI2C_BOOT_UART;
            phase_reg <= 2'h0;
            bit_reg <= 3'h0;
            cmd_reg <= 3'h0;
            sh_reg <= 8'h00;
            nack_reg <= 1'h0;
            scl_reg <= 1'h1;
            sdo_reg <= 1'h1;
            ACK_O <= 1'h0;
            DONE_O <= 1'h0;
            RD_DATA_O <= 8'h00;
        end else begin
            div_reg <= (tick || state_reg == SEI2C_ST_READY) ? 16'h0000
                       : div_reg + 16'h0001;
            DONE_O <= 1'h0;
            unique case (state_reg)
                SEI2C_ST_BOOT: begin
                    // Start-up mode follows the synchronised pin every cycle while in the boot state
                    boot_reg <= boot_s2_reg ? SEI2C_BOOT_FIFO
                                            : SEI2C_BOOT_UART;
                    if (ENGINE_EN_I) begin
                        state_reg <= SEI2C_ST_READY;
                    end
                end
                SEI2C_ST_READY: begin
                    phase_reg <= 2'h0;
                    bit_reg <= 3'h7;
                    if (!ENGINE_EN_I) begin
                        state_reg <= SEI2C_ST_BOOT;
                    end else if (CMD_VALID_I) begin
                        cmd_reg <= CMD_I;
                        sh_reg <= CMD_DATA_I;
                        nack_reg <= CMD_NACK_I;
                        unique case (CMD_I)
                            SEI2C_CMD_START: state_reg <= SEI2C_ST_START;
                            SEI2C_CMD_STOP: state_reg <= SEI2C_ST_STOP;
                            SEI2C_CMD_WRITE,
                            SEI2C_CMD_READ: state_reg <= SEI2C_ST_BITS;
                            default: begin
                                scl_reg <= 1'h1;
                                sdo_reg <= 1'h1;
                                state_reg <= SEI2C_ST_DONE;
                            end
                        endcase
                    end
                end
                SEI2C_ST_START: if (tick) begin
                    // SDA falls while SCL high, then SCL falls
                    phase_reg <= phase_reg + 2'h1;
                    unique case (phase_reg)
                        2'h0: begin
                            sdo_reg <= 1'h1;
                            scl_reg <= 1'h1;
                        end
                        2'h1: sdo_reg <= 1'h0;
                        2'h2: scl_reg <= 1'h0;
                        2'h3: state_reg <= SEI2C_ST_DONE;
                    endcase
                end
                SEI2C_ST_STOP: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    unique case (phase_reg)
                        2'h0: sdo_reg <= 1'h0;
                        2'h1: scl_reg <= 1'h1;
                        2'h2: sdo_reg <= 1'h1;
                        2'h3: state_reg <= SEI2C_ST_DONE;
                    endcase
                end
                SEI2C_ST_BITS, SEI2C_ST_ACK: if (tick) begin
                    phase_reg <= phase_end ? 2'h0 : phase_reg + 2'h1;
                    unique case (phase_reg)
                        2'h0: begin
                            // Data set while SCL low
                            if (state_reg == SEI2C_ST_ACK) begin
                                sdo_reg <= is_read ? nack_reg : 1'h1;
                            end else begin
                                sdo_reg <= is_read ? 1'h1 : sh_reg[7];
                            end
                        end
                        2'h1: scl_reg <= 1'h1;
                        2'h2: begin
                            scl_reg <= 1'h0;
                            if (state_reg == SEI2C_ST_ACK && !is_read) begin
                                ACK_O <= !sda_in;
                            end else if (state_reg == SEI2C_ST_BITS) begin
                                sh_reg <= {sh_reg[6:0], sda_in};
                            end
                        end
                        default: ;
                    endcase
                    if (phase_end) begin
                        if (state_reg == SEI2C_ST_ACK) begin
                            RD_DATA_O <= sh_reg;
                            state_reg <= SEI2C_ST_DONE;
                        end else if (bit_reg == 3'h0) begin
                            state_reg <= SEI2C_ST_ACK;
                        end else begin
                            bit_reg <= bit_reg - 3'h1;
                        end
                    end
                end
                SEI2C_ST_DONE: begin
                    DONE_O <= 1'h1;
                    state_reg <= SEI2C_ST_READY;
                end
            endcase
        end
    end

    // ****************************************************************
    // Pin drive: boot modes, engine lines and GPIO
    // ****************************************************************
    wire engine = (state_reg != SEI2C_ST_BOOT);
    wire [7:0] io_mask = ~8'(`SEI2C_ENGINE_OE_LOW | (8'h01 << `SEI2C_SDI_BIT));
    // Engine lines: SCL always driven, SDO released as open drain
    wire [7:0] eng_val = {5'h00, 1'b0, sdo_reg, scl_reg};
    wire [7:0] eng_oe = {5'h00, 1'b0, ~sdo_reg, 1'b1};
    wire [7:0] lo_gp_oe = LO_DIR_I & ~(LO_OD_I & LO_VAL_I);
    wire [7:0] hi_gp_oe = HI_DIR_I & ~(HI_OD_I & HI_VAL_I);
    wire fifo_boot = (boot_reg == SEI2C_BOOT_FIFO);
    wire [7:0] fifo_hi = fifo_boot ? 8'(`SEI2C_FIFO_HI_MASK) : 8'h00;
    wire [7:0] lo_val_n = engine ? ((LO_VAL_I & io_mask) | eng_val)
                       : (fifo_boot ? 8'h00 : 8'(`SEI2C_UART_IDLE));
    wire [7:0] lo_oe_n = engine ? ((lo_gp_oe & io_mask) | eng_oe)
                       : (fifo_boot ? 8'h00
                                    : 8'(`SEI2C_UART_IDLE_OE));
    // FIFO-owned high lines keep FIFO values, never GPIO
    wire [7:0] hi_val_n = (HI_VAL_I & ~fifo_hi) | (HI_FIFO_VAL_I & fifo_hi);
    wire [7:0] hi_oe_n = (engine ? hi_gp_oe : 8'h00) & ~fifo_hi
                       | fifo_hi;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            LO_PIN_O <= 8'h00;
            LO_PIN_OE_O <= 8'h00;
            HI_PIN_O <= 8'h00;
            HI_PIN_OE_O <= 8'h00;
            ENGINE_MODE_O <= 1'h0;
            CMD_READY_O <= 1'h0;
            LO_IN_O <= 8'hFF;
            HI_IN_O <= 8'hFF;
        end else begin
            LO_PIN_O <= lo_val_n;
            LO_PIN_OE_O <= lo_oe_n;
            HI_PIN_O <= hi_val_n;
            HI_PIN_OE_O <= hi_oe_n;
            ENGINE_MODE_O <= engine;
            CMD_READY_O <= (state_reg == SEI2C_ST_READY) && !CMD_VALID_I;
            LO_IN_O <= lo_s2_reg;
            HI_IN_O <= hi_s2_reg;
        end
    end
endmodule // sei2c_master

// *** sim/sei2c_chk.sv ***
/* Assertions on the pins of sei2c_master.
   Bound to the master; sees only its ports. */
`timescale 1ns/100ps
`include "sei2c_params.svh"
module sei2c_chk import sei2c_pkg::*; (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic BOOT_FIFO_I,
    input wire logic ENGINE_EN_I,
    input wire logic THREE_PHASE_I,
    input wire logic CMD_VALID_I,
    input wire logic [2:0] CMD_I,
    input wire logic [7:0] HI_DIR_I,
    input wire logic [7:0] HI_VAL_I,
    input wire logic [7:0] HI_OD_I,
    input wire logic [7:0] LO_PIN_O,
    input wire logic [7:0] LO_PIN_OE_O,
    input wire logic [7:0] HI_PIN_O,
    input wire logic [7:0] HI_PIN_OE_O,
    input wire logic ENGINE_MODE_O,
    input wire logic CMD_READY_O
);
    logic scl_d_reg;
    logic [3:0] rise_reg;
    logic [2:0] cmd_reg;
    wire take = CMD_VALID_I && CMD_READY_O && ENGINE_EN_I;
    wire scl_rise = LO_PIN_O[0] && !scl_d_reg;
    wire is_byte = cmd_reg == SEI2C_CMD_WRITE || cmd_reg == SEI2C_CMD_READ;
    wire in_byte = is_byte && rise_reg != 4'h0 && rise_reg < 4'h9;
    // ********
    // Clock rises counted since the last accepted command
    // ********
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            scl_d_reg <= 1'b0;
            rise_reg <= 4'h0;
            cmd_reg <= 3'h4;
        end else begin
            scl_d_reg <= LO_PIN_O[0];
            rise_reg <= take ? 4'h0 : rise_reg + {3'h0, scl_rise};
            cmd_reg <= take ? CMD_I : cmd_reg;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence s_fifo_start;
        (!ENGINE_EN_I && BOOT_FIFO_I) [*6];
    endsequence
    sequence s_uart_start;
        (!ENGINE_EN_I && !BOOT_FIFO_I) [*6];
    endsequence
    sequence s_ack_clock;
        scl_rise && rise_reg == 4'h8 && cmd_reg == SEI2C_CMD_WRITE;
    endsequence
    AST_FIFO_BOOT: assert property (s_fifo_start |-> LO_PIN_OE_O == 8'h00)
        else $error("low port driven in fifo start");
    AST_UART_BOOT: assert property (s_uart_start |->
        LO_PIN_OE_O == `SEI2C_UART_IDLE_OE && LO_PIN_O == `SEI2C_UART_IDLE)
        else $error("low port not at uart idle");
    AST_ENGINE_ENTRY: assert property ($rose(ENGINE_EN_I) |-> ##[1:4] ENGINE_MODE_O)
        else $error("engine mode not entered");
    AST_SCL_OUT: assert property (ENGINE_MODE_O && $past(ENGINE_MODE_O) |-> LO_PIN_OE_O[0])
        else $error("clock pin not driven");
    AST_SDI_IN: assert property (ENGINE_MODE_O && $past(ENGINE_MODE_O) |-> !LO_PIN_OE_O[2])
        else $error("data-in pin driven");
    AST_SDA_OD: assert property (ENGINE_MODE_O && LO_PIN_OE_O[1] |-> !LO_PIN_O[1])
        else $error("data-out driven high");
    AST_ACK_FREE: assert property (s_ack_clock |-> !LO_PIN_OE_O[1])
        else $error("data-out held during ack clock");
    AST_HOLD: assert property ($fell(LO_PIN_O[0]) && THREE_PHASE_I && in_byte
        |-> $stable(LO_PIN_OE_O[1]) [*8])
        else $error("data moved after clock fall");
    AST_HI_OD: assert property (ENGINE_MODE_O && $past(HI_OD_I[7])
        && $past(HI_VAL_I[7]) |-> !HI_PIN_OE_O[7])
        else $error("open-drain line driven high");
    AST_HI_GPIO: assert property (ENGINE_MODE_O && $past(ENGINE_MODE_O)
        && $past(HI_DIR_I[6]) && !$past(HI_OD_I[6])
        |-> HI_PIN_OE_O[6] && HI_PIN_O[6] == $past(HI_VAL_I[6]))
        else $error("gpio output wrong");
endmodule // sei2c_chk

bind sei2c_master sei2c_chk u_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .BOOT_FIFO_I(BOOT_FIFO_I), .ENGINE_EN_I(ENGINE_EN_I),
    .THREE_PHASE_I(THREE_PHASE_I), .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I),
    .HI_DIR_I(HI_DIR_I), .HI_VAL_I(HI_VAL_I), .HI_OD_I(HI_OD_I),
    .LO_PIN_O(LO_PIN_O), .LO_PIN_OE_O(LO_PIN_OE_O), .HI_PIN_O(HI_PIN_O),
    .HI_PIN_OE_O(HI_PIN_OE_O), .ENGINE_MODE_O(ENGINE_MODE_O),
    .CMD_READY_O(CMD_READY_O));

// *** sim/sei2c_slave.sv ***
/* Behavioural I2C slave sensor on the shared bus.
   Assumes a pulled-up data line; it only ever pulls low. */
`timescale 1ns/100ps
module sei2c_slave (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic rd_i,
    input wire logic ack_i,
    input wire logic [7:0] byte_i,
    output logic sda_low_o
);
    int cnt = 0;
    initial sda_low_o = 1'b0;
    // ********
    // Start restarts the count; bits change only while the clock is low
    // ********
    always @(negedge sda_i) if (scl_i) cnt = 0;
    always @(posedge scl_i) cnt++;
    always @(posedge rd_i) sda_low_o <= !byte_i[7];
    always @(negedge scl_i) begin
        if (cnt == 8)
            sda_low_o <= !rd_i && ack_i;
        else if (cnt < 8)
            sda_low_o <= rd_i && !byte_i[7 - cnt];
        else begin
            sda_low_o <= rd_i && !sda_i && !byte_i[7];
            cnt = 0;
        end
    end
endmodule // sei2c_slave

// *** sim/testbench.sv ***
/* Self-checking bench for sei2c_master with one slave model.
   Assumes the params header on the include path. */
`timescale 1ns/100ps
`include "sei2c_params.svh"
module testbench import sei2c_pkg::*;;
    logic clk, rst_n, boot, eng, tph, cv, nack, srd, sack;
    logic [2:0] cmd;
    logic [7:0] cdat, hdir, hval, hod, lo_o, lo_oe, hi_o, hi_oe, rdat;
    logic [8:0] mon;
    logic [7:0] lin, hin;
    logic emode, rdy, done, ack, slow;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    wire sda = (lo_oe[1] ? lo_o[1] : 1'b1) & !slow;
    sei2c_master uut (.CLK_I(clk), .RESET_N_I(rst_n), .BOOT_FIFO_I(boot),
        .ENGINE_EN_I(eng), .THREE_PHASE_I(tph), .CMD_VALID_I(cv),
        .CMD_I(cmd), .CMD_DATA_I(cdat), .CMD_NACK_I(nack),
        .LO_DIR_I(8'h03), .LO_VAL_I(8'h00), .LO_OD_I(8'h00),
        .HI_DIR_I(hdir), .HI_VAL_I(hval), .HI_OD_I(hod),
        .HI_FIFO_VAL_I(8'h05), .LO_PIN_I({5'h15, sda, sda, lo_o[0]}),
        .HI_PIN_I(hi_o), .LO_PIN_O(lo_o), .LO_PIN_OE_O(lo_oe),
        .HI_PIN_O(hi_o), .HI_PIN_OE_O(hi_oe), .ENGINE_MODE_O(emode),
        .CMD_READY_O(rdy), .DONE_O(done), .ACK_O(ack), .RD_DATA_O(rdat),
        .LO_IN_O(lin), .HI_IN_O(hin));
    sei2c_slave slv (.scl_i(lo_o[0]), .sda_i(sda), .rd_i(srd), .ack_i(sack),
        .byte_i(8'h5B), .sda_low_o(slow));
    always @(posedge lo_o[0]) mon <= {mon[7:0], sda};
    // ********
    // Shared tasks
    // ********
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [2:0] c, input logic [7:0] d);
        int n;
        @(negedge clk);
        while (!rdy) @(negedge clk);
        cmd = c;
        cdat = d;
        cv = 1'b1;
        @(negedge clk);
        cv = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, done}, 8'h01);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic t_boot;
        repeat (6) @(negedge clk);
        chk(lo_oe, `SEI2C_UART_IDLE_OE);
        chk(lo_o, `SEI2C_UART_IDLE);
        boot = 1'b1;
        repeat (6) @(negedge clk);
        chk(lo_oe, 8'h00);
        eng = 1'b1;
        repeat (6) @(negedge clk);
        chk({3'h0, emode, rdy, lo_oe[2:0]}, 8'h19);
        $display("start-up test done");
    endtask
    task automatic t_gpio;
        hdir = 8'hC0;
        hod = 8'h80;
        hval = 8'h40;
        repeat (3) @(negedge clk);
        chk(hi_oe & 8'hC0, 8'hC0);
        chk(hi_o & 8'hC0, 8'h40);
        hval = 8'h80;
        repeat (3) @(negedge clk);
        chk(hi_oe & 8'hC0, 8'h40);
        chk(hi_o & 8'h40, 8'h00);
        $display("gpio test done");
    endtask
    task automatic t_write(input logic [7:0] b, input logic a);
        sack = a;
        run(SEI2C_CMD_WRITE, b);
        chk(mon[8:1], b);
        chk({7'h00, mon[0]}, {7'h00, !a});
        chk({7'h00, ack}, {7'h00, a});
    endtask
    task automatic t_frame;
        run(SEI2C_CMD_START, 8'h00);
        t_write(8'hA6, 1'b1);
        t_write(8'h3C, 1'b0);
        tph = 1'b1;
        nack = 1'b1;
        srd = 1'b1;
        run(SEI2C_CMD_READ, 8'h00);
        srd = 1'b0;
        chk(rdat, 8'h5B);
        chk({7'h00, mon[0]}, 8'h01);
        run(SEI2C_CMD_STOP, 8'h00);
        run(SEI2C_CMD_IDLE, 8'h00);
        chk({6'h00, lo_o[0], sda}, 8'h03);
        chk(lin, 8'hAF);
        chk(hin, 8'h85);
        $display("transfer test done");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            errors++;
            print_verdict;
        end
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rst_n, boot, eng, tph, cv, nack, srd, sack} = 8'h00;
        {cmd, cdat, hdir, hval, hod, mon} = {3'h4, 41'h00000000000};
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_boot;
        t_gpio;
        t_frame;
        print_verdict;
    end
endmodule // testbench
